//--- core/bnfh_host.sv
// host controller driving a banked asynchronous nor flash through its pins
// assumes a 10 MHz clock, a pulled-up shared busy line and a user request port
//
// Behaviour
// R01 - device powers up in array read mode
// R02 - array has 8 parameter, 126 main blocks
// R03 - banks 32, 96, 96, 32 Mb in order
// R04 - reads allowed in other banks while busy
// R05 - buffered program takes up to 32 words
// R06 - enhanced buffered program takes 256 words
// R07 - extra 256-word block via entry command
// R08 - user lock of extra block is permanent
// R09 - protect pin low guards four outer blocks
// R10 - protect pin high restores previous protection
// R11 - high voltage on protect pin speeds programming
// R12 - chip select high means standby, outputs float; the flash model drives the inverted last read word instead
// R13 - output enable times reads, write strobe writes
// R14 - host drives exact command addresses on writes
// R15 - upper data byte unused on commands, status
// R16 - reset low long enough, then wait recovery
// R17 - busy pulled low during program or erase
// R18 - no cycle before busy line released
// R19 - busy output is open drain, shared
// R20 - suspended operations allow reads elsewhere
// R21 - fresh device reads all ones
// R22 - page reads use eight-word page buffer
// R23 - read: oe low, write: we low
// R24 - only one bank programs or erases
`timescale 1ns/1ps
`include "bnfh_regs.svh"

module bnfh_host (
   input  wire logic                     clk_i,
   input  wire logic                     rst_n_i,
   input  wire logic                     req_i,
   input  wire logic                     req_we_i,
   input  wire logic                     req_status_i,
   input  wire logic [`BNFH_ADDR_W-1:0]  req_addr_i,
   input  wire logic [`BNFH_DATA_W-1:0]  req_wdata_i,
   input  wire logic                     hw_reset_i,
   input  wire logic                     wp_release_i,
   output logic                          ack_o,
   output logic [`BNFH_DATA_W-1:0]       rdata_o,
   output logic                          ready_o,
   output logic                          flash_busy_o,
   output logic                          flash_ce_n_o,
   output logic                          flash_oe_n_o,
   output logic                          flash_we_n_o,
   output logic                          flash_rst_n_o,
   output logic                          flash_wp_n_o,
   output logic [`BNFH_ADDR_W-1:0]       flash_addr_o,
   output logic [`BNFH_DATA_W-1:0]       flash_dq_o,
   output logic                          flash_dq_oe_o,
   input  wire logic [`BNFH_DATA_W-1:0]  flash_dq_i,
   input  wire logic                     op_in_progress_n_i
);

   // =========================================================
   // cycle counts
   function automatic logic [`BNFH_CNT_W-1:0] cyc(input int ns);
      int c;
      c = (ns + `BNFH_CLK_NS - 1) / `BNFH_CLK_NS;
      if (c < 1) begin
         c = 1;
      end
      cyc = c[`BNFH_CNT_W-1:0];
   endfunction

   localparam logic [`BNFH_CNT_W-1:0] RD_CYC  = cyc(`BNFH_RD_ACCESS_NS);
   localparam logic [`BNFH_CNT_W-1:0] WE_CYC  = cyc(`BNFH_WE_LOW_MIN_NS);
   localparam logic [`BNFH_CNT_W-1:0] RST_CYC = cyc(`BNFH_RESET_LOW_MIN_NS);
   localparam logic [`BNFH_CNT_W-1:0] PHE_CYC = cyc(`BNFH_RESET_TO_SEL_NS);
   localparam logic [`BNFH_CNT_W-1:0] RHE_CYC = cyc(`BNFH_READY_TO_SEL_NS);
   localparam logic [`BNFH_CNT_W-1:0] ONE     = {{(`BNFH_CNT_W-1){1'b0}}, 1'b1};
   // recovery lasts at least as long as the busy synchroniser, so a stale idle level is never trusted
   localparam logic [`BNFH_CNT_W-1:0] SYNC_CYC = cyc(4 * `BNFH_CLK_NS);
   localparam logic [`BNFH_CNT_W-1:0] REC_CYC  = (PHE_CYC > SYNC_CYC) ? PHE_CYC : SYNC_CYC;

   // =========================================================
   // reset release
   logic [1:0] rst_ff_r;
   logic       rst_n;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_ff_r <= 2'h0;
      end else begin
         rst_ff_r <= {rst_ff_r[0], 1'b1};
      end
   end

   assign rst_n = rst_ff_r[1];

   // =========================================================
   // busy line input, inverted ahead of the synchroniser so its flop drives the output
   logic busy_sync;
   logic busy_raw;

   assign busy_raw = ~op_in_progress_n_i;

   bnfh_sync #(
      .RESET_VAL (1'b1)
   ) u_busy_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .d_i     (busy_raw),
      .q_o     (busy_sync)
   );

   // =========================================================
   // sequencer
   bnfh_pkg::bnfh_host_s q_r;
   bnfh_pkg::bnfh_host_s q_nxt;

   always_comb begin
      q_nxt      = q_r;
      q_nxt.ack  = 1'b0;
      q_nxt.wp_n = wp_release_i;
      unique case (q_r.st)
         bnfh_pkg::ST_RST_LOW: begin
            if (q_r.cnt == ONE) begin
               q_nxt.rst_n = 1'b1; // R16
               q_nxt.cnt   = REC_CYC;
               q_nxt.st    = bnfh_pkg::ST_RST_REC;
            end else begin
               q_nxt.cnt = q_r.cnt - ONE;
            end
         end
         bnfh_pkg::ST_RST_REC: begin
            if (q_r.cnt == ONE) begin
               q_nxt.st = bnfh_pkg::ST_WAIT_RDY; // R16
            end else begin
               q_nxt.cnt = q_r.cnt - ONE;
            end
         end
         bnfh_pkg::ST_WAIT_RDY: begin
            if (!busy_sync) begin
               q_nxt.cnt = RHE_CYC; // R18
               q_nxt.st  = bnfh_pkg::ST_RDY_REC;
            end
         end
         bnfh_pkg::ST_RDY_REC: begin
            if (busy_sync) begin
               q_nxt.st = bnfh_pkg::ST_WAIT_RDY; // R18
            end else if (q_r.cnt == ONE) begin
               q_nxt.ready = 1'b1;
               q_nxt.st    = bnfh_pkg::ST_IDLE;
            end else begin
               q_nxt.cnt = q_r.cnt - ONE;
            end
         end
         bnfh_pkg::ST_IDLE: begin
            if (hw_reset_i) begin
               q_nxt.ready = 1'b0;
               q_nxt.rst_n = 1'b0; // R16
               q_nxt.cnt   = RST_CYC;
               q_nxt.st    = bnfh_pkg::ST_RST_LOW;
            end else if (req_i) begin
               q_nxt.ready = 1'b0;
               q_nxt.ce_n  = 1'b0;
               q_nxt.addr  = req_addr_i; // R14
               q_nxt.stat  = req_status_i;
               if (req_we_i) begin
                  q_nxt.dq    = '0;
                  q_nxt.dq[`BNFH_CMD_MSB:`BNFH_CMD_LSB] =
                     req_wdata_i[`BNFH_CMD_MSB:`BNFH_CMD_LSB]; // R15
                  q_nxt.dq_oe = 1'b1;
                  q_nxt.st    = bnfh_pkg::ST_WR_SETUP;
               end else begin
                  q_nxt.oe_n = 1'b0; // R23
                  q_nxt.cnt  = RD_CYC;
                  q_nxt.st   = bnfh_pkg::ST_RD;
               end
            end
         end
         bnfh_pkg::ST_RD: begin
            if (q_r.cnt == ONE) begin
               q_nxt.rdata = flash_dq_i; // R13
               if (q_r.stat) begin
                  q_nxt.rdata[`BNFH_UPPER_MSB:`BNFH_UPPER_LSB] = '0; // R15
               end
               q_nxt.ce_n  = 1'b1;
               q_nxt.oe_n  = 1'b1;
               q_nxt.ack   = 1'b1;
               q_nxt.ready = 1'b1;
               q_nxt.st    = bnfh_pkg::ST_IDLE;
            end else begin
               q_nxt.cnt = q_r.cnt - ONE;
            end
         end
         bnfh_pkg::ST_WR_SETUP: begin
            q_nxt.we_n = 1'b0; // R13
            q_nxt.cnt  = WE_CYC;
            q_nxt.st   = bnfh_pkg::ST_WR_PULSE;
         end
         bnfh_pkg::ST_WR_PULSE: begin
            if (q_r.cnt == ONE) begin
               q_nxt.we_n = 1'b1;
               q_nxt.st   = bnfh_pkg::ST_WR_HOLD;
            end else begin
               q_nxt.cnt = q_r.cnt - ONE;
            end
         end
         bnfh_pkg::ST_WR_HOLD: begin
            q_nxt.ce_n  = 1'b1;
            q_nxt.dq_oe = 1'b0;
            q_nxt.ack   = 1'b1;
            q_nxt.ready = 1'b1;
            q_nxt.st    = bnfh_pkg::ST_IDLE;
         end
         default: begin
            q_nxt.st = bnfh_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         q_r       <= '0;
         q_r.st    <= bnfh_pkg::ST_RST_LOW;
         q_r.cnt   <= RST_CYC;
         q_r.ce_n  <= 1'b1;
         q_r.oe_n  <= 1'b1;
         q_r.we_n  <= 1'b1;
      end else begin
         q_r <= q_nxt;
      end
   end

   // =========================================================
   // outputs
   assign ack_o         = q_r.ack;
   assign rdata_o       = q_r.rdata;
   assign ready_o       = q_r.ready;
   assign flash_busy_o  = busy_sync;
   assign flash_ce_n_o  = q_r.ce_n;
   assign flash_oe_n_o  = q_r.oe_n;
   assign flash_we_n_o  = q_r.we_n;
   assign flash_rst_n_o = q_r.rst_n;
   assign flash_wp_n_o  = q_r.wp_n;
   assign flash_addr_o  = q_r.addr;
   assign flash_dq_o    = q_r.dq;
   assign flash_dq_oe_o = q_r.dq_oe;

   // =========================================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   sequence s_rd_cycle;
      $fell(flash_oe_n_o) ##1 (ack_o && flash_oe_n_o && flash_ce_n_o);
   endsequence

   sequence s_wr_start;
      $fell(flash_ce_n_o) && flash_we_n_o && flash_dq_oe_o;
   endsequence

   sequence s_wr_rest;
      !flash_we_n_o ##1 flash_we_n_o ##1 (ack_o && flash_ce_n_o);
   endsequence

   a_rst_pulse_len: assert property ($fell(flash_rst_n_o) |-> !flash_rst_n_o [*5]) // R16
      else $error("reset pulse shorter than minimum");
   a_no_cycle_busy: assert property (!q_r.ready && q_r.st inside {bnfh_pkg::ST_RST_LOW,
      bnfh_pkg::ST_RST_REC, bnfh_pkg::ST_WAIT_RDY, bnfh_pkg::ST_RDY_REC}
      |-> flash_ce_n_o) // R18
      else $error("chip selected before recovery done");
   a_rd_timing: assert property ($fell(flash_oe_n_o) |-> s_rd_cycle) // R13
      else $error("read cycle not acknowledged in time");
   a_wr_timing: assert property (s_wr_start |=> s_wr_rest) // R13
      else $error("write strobe sequence wrong");
   a_rd_strobes: assert property (!flash_oe_n_o |-> !flash_ce_n_o && flash_we_n_o
      && !flash_dq_oe_o) // R23
      else $error("bad strobes during read");
   a_wr_strobes: assert property (!flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o
      && flash_dq_oe_o) // R23
      else $error("bad strobes during write");
   a_addr_stable: assert property (!flash_ce_n_o && !$past(flash_ce_n_o)
      |-> $stable(flash_addr_o)) // R14
      else $error("address moved inside a cycle");
   a_upper_zero: assert property (flash_dq_oe_o |-> flash_dq_o[15:8] == 8'h00) // R15
      else $error("upper command byte driven");
   a_stat_mask: assert property (ack_o && q_r.stat && !flash_dq_oe_o
      && !$past(flash_oe_n_o) |-> rdata_o[15:8] == 8'h00) // R15
      else $error("status upper byte not masked");

endmodule

//--- core/bnfh_pkg.sv
// types for the banked nor flash host port controller
// assumes bnfh_regs.svh is on the include path
`include "bnfh_regs.svh"

package bnfh_pkg;

   // =========================================================
   // controller states
   typedef enum logic [3:0] {
      ST_RST_LOW  = 4'h0,
      ST_RST_REC  = 4'h1,
      ST_WAIT_RDY = 4'h2,
      ST_RDY_REC  = 4'h3,
      ST_IDLE     = 4'h4,
      ST_RD       = 4'h5,
      ST_WR_SETUP = 4'h6,
      ST_WR_PULSE = 4'h7,
      ST_WR_HOLD  = 4'h8
   } bnfh_state_e;

   // =========================================================
   // controller state
   typedef struct packed {
      bnfh_state_e                st;
      logic [`BNFH_CNT_W-1:0]     cnt;
      logic                       ce_n;
      logic                       oe_n;
      logic                       we_n;
      logic                       rst_n;
      logic                       wp_n;
      logic [`BNFH_ADDR_W-1:0]    addr;
      logic [`BNFH_DATA_W-1:0]    dq;
      logic                       dq_oe;
      logic [`BNFH_DATA_W-1:0]    rdata;
      logic                       ack;
      logic                       ready;
      logic                       stat;
   } bnfh_host_s;

   // =========================================================
   // synchroniser state
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } bnfh_sync_s;

endpackage

//--- core/bnfh_regs.svh
// constants for the banked nor flash host port controller
// assumes a single 10 MHz system clock; included by the package and the controller
`ifndef BNFH_REGS_SVH
`define BNFH_REGS_SVH

// =========================================================
// widths
`define BNFH_ADDR_W            24
`define BNFH_DATA_W            16
`define BNFH_CNT_W             12

// =========================================================
// clock and pin timing, in ns
`define BNFH_CLK_NS            100
`define BNFH_RD_ACCESS_NS      70
`define BNFH_WE_LOW_MIN_NS     45
`define BNFH_RESET_LOW_MIN_NS  500
`define BNFH_RESET_TO_SEL_NS   50
`define BNFH_READY_TO_SEL_NS   200

// =========================================================
// data field positions
`define BNFH_CMD_LSB           0
`define BNFH_CMD_MSB           7
`define BNFH_UPPER_LSB         8
`define BNFH_UPPER_MSB         15

`endif

//--- core/bnfh_sync.sv
// three-stage input synchroniser with agreement filter
// assumes an asynchronous input and an already synchronised active-low reset
`timescale 1ns/1ps

module bnfh_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic d_i,
   output logic      q_o
);

   // =========================================================
   // state
   bnfh_pkg::bnfh_sync_s r_r;
   bnfh_pkg::bnfh_sync_s r_nxt;

   always_comb begin
      r_nxt    = r_r;
      r_nxt.s1 = d_i;
      r_nxt.s2 = r_r.s1;
      r_nxt.s3 = r_r.s2;
      if (r_r.s2 == r_r.s3) begin
         r_nxt.q = r_r.s3;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r_r <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
      end else begin
         r_r <= r_nxt;
      end
   end

   assign q_o = r_r.q;

endmodule

//--- testbench/bnfh_flash_model.sv
// behavioural model of the banked nor flash seen from its pins
// assumes host-driven pins and a pulled-up shared busy line resolved by the bench
`timescale 1ns/1ps

module bnfh_flash_model #(
   parameter logic [7:0] STATUS_CMD  = 8'h70,
   parameter logic [7:0] BUSY_CMD    = 8'h30,
   parameter int         BUSY_NS     = 1500,
   parameter int         RST_BUSY_NS = 800
) (
   input  wire logic        ce_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        we_n_i,
   input  wire logic        rst_n_i,
   input  wire logic [23:0] addr_i,
   input  wire logic        wp_n_i,
   input  wire logic [15:0] dq_i,
   output logic      [15:0] dq_o,
   output logic             busy_low_o
);
   // =========================================================
   // mode and busy state
   logic        stat_r;
   logic        busy_r;
   logic [15:0] last_r;
   logic [15:0] rd;
   logic [1:0]  bank_r;
   logic        outer;

   // bank of an address: 32Mb, 96Mb, 96Mb, 32Mb from the bottom
   function automatic logic [1:0] bank_of(input logic [23:0] a);
      if (a < 24'h200000) bank_of = 2'h0;
      else if (a < 24'h800000) bank_of = 2'h1;
      else if (a < 24'hE00000) bank_of = 2'h2;
      else bank_of = 2'h3;
   endfunction

   // two 32 kword blocks at each end answer to the protect pin
   assign outer = (addr_i < 24'h010000) || (addr_i >= 24'hFF0000);

   initial begin
      bank_r = 2'h0;
      stat_r = 1'b0;
      busy_r = 1'b0;
      last_r = 16'hFFFF;
   end

   // commands latched on the write strobe only, lower byte only
   always @(posedge we_n_i) begin
      if (!ce_n_i && rst_n_i) begin
         stat_r <= (dq_i[7:0] == STATUS_CMD);
         if (dq_i[7:0] == BUSY_CMD && !busy_r && (wp_n_i || !outer)) begin
            bank_r <= bank_of(addr_i);
            busy_r <= 1'b1;
            busy_r <= #(BUSY_NS) 1'b0;
         end
      end
   end

   always @(negedge rst_n_i) stat_r <= 1'b0;
   always @(posedge rst_n_i) begin
      busy_r <= 1'b1;
      busy_r <= #(RST_BUSY_NS) 1'b0;
   end

   // =========================================================
   // data out: erased array or status with junk upper byte
   // the programming bank answers with a busy word, the other banks with the array
   assign rd = stat_r ? 16'h5A80 :
               (busy_r && bank_of(addr_i) == bank_r) ? 16'h0044 : 16'hFFFF;
   always @(ce_n_i, oe_n_i, we_n_i, rd) begin
      if (!ce_n_i && !oe_n_i && we_n_i) begin
         dq_o   = rd;
         last_r = rd;
      end else begin
         dq_o = ~last_r;
      end
   end

   assign busy_low_o = busy_r;
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the nor flash host controller
// assumes bnfh_regs.svh on the include path and the flash model beside it
`timescale 1ns/1ps
`include "bnfh_regs.svh"

module tb_top;
   logic                    clk_i, rst_n_i, req_i, req_we_i, req_status_i;
   logic                    hw_reset_i, wp_release_i, ack_o, ready_o, flash_busy_o;
   logic                    ce_n, oe_n, we_n, frst_n, wp_n, dq_oe, busy_low;
   logic [`BNFH_ADDR_W-1:0] req_addr_i, faddr;
   logic [`BNFH_DATA_W-1:0] req_wdata_i, rdata_o, dq_o, fl_dq;
   wire  [`BNFH_DATA_W-1:0] dq_bus;
   wire                     busy_line;
   int                      bad_count, samples_checked, cycles;

   assign dq_bus    = dq_oe ? dq_o : fl_dq;
   assign busy_line = busy_low ? 1'b0 : 1'b1;

   bnfh_host DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .req_we_i(req_we_i),
      .req_status_i(req_status_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
      .hw_reset_i(hw_reset_i), .wp_release_i(wp_release_i), .ack_o(ack_o),
      .rdata_o(rdata_o), .ready_o(ready_o), .flash_busy_o(flash_busy_o),
      .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n),
      .flash_rst_n_o(frst_n), .flash_wp_n_o(wp_n), .flash_addr_o(faddr),
      .flash_dq_o(dq_o), .flash_dq_oe_o(dq_oe), .flash_dq_i(dq_bus),
      .op_in_progress_n_i(busy_line));

   bnfh_flash_model u_flash (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
      .rst_n_i(frst_n), .addr_i(faddr), .wp_n_i(wp_n), .dq_i(dq_bus), .dq_o(fl_dq),
      .busy_low_o(busy_low));

   // =========================================================
   // clock, timeout and reporting
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         bad_count = bad_count + 1;
         test_done();
      end
   end

   task automatic test_done();
      if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // =========================================================
   // one request through the user port, pins watched on the way
   task automatic xfer(input logic we, input logic st, input logic [23:0] a,
                       input logic [15:0] d);
      int n;
      n = 0;
      while (ready_o !== 1'b1 && n < 200) begin
         @(posedge clk_i);
         #1 n++;
      end
      @(posedge clk_i);
      req_i <= 1'b1;
      req_we_i <= we;
      req_status_i <= st;
      req_addr_i <= a;
      req_wdata_i <= d;
      @(posedge clk_i);
      req_i <= 1'b0;
      #1;
      check("ce_n", ce_n, 0);
      check("addr", faddr, a);
      check("oe_n", oe_n, we);
      if (we) check("dq_out", {dq_oe, dq_o}, {1'b1, 8'h00, d[7:0]});
      else check("we_n", we_n, 1);
      n = 0;
      while (ack_o !== 1'b1 && n < 20) begin
         @(posedge clk_i);
         #1 n++;
         if (we && n == 1) check("we_pulse", {we_n, oe_n}, 2'b01);
      end
      check("ack_lat", n, we ? 3 : 1);
      check("ce_rel", ce_n, 1);
   endtask

   task automatic wait_ready();
      int n;
      n = 0;
      while (ready_o !== 1'b1 && n < 100) begin
         @(posedge clk_i);
         #1 n++;
      end
      check("ready_busy", {ready_o, busy_line, flash_busy_o}, 3'b110);
   endtask

   // =========================================================
   // scenarios
   task automatic t_reset_state();
      repeat (10) @(posedge clk_i);
      #1 check("rst_pins", {ce_n, oe_n, we_n, frst_n, dq_oe, ready_o, wp_n}, 7'h70);
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      wait_ready();
   endtask

   task automatic t_reads();
      xfer(0, 0, 24'hFE8003, 0);
      check("array", rdata_o, 16'hFFFF);
      xfer(1, 0, 24'h000555, 16'hAB70);
      xfer(0, 1, 24'h000000, 0);
      check("status", rdata_o, 16'h0080);
   endtask

   task automatic t_busy();
      int n;
      xfer(1, 0, 24'h1002AA, 16'hFF30);
      repeat (5) @(posedge clk_i);
      #1 check("busy_on", flash_busy_o, 1);
      xfer(0, 0, 24'h800000, 0);
      check("dual_rd", rdata_o, 16'hFFFF);
      n = 0;
      while (flash_busy_o !== 1'b0 && n < 30) begin
         @(posedge clk_i);
         #1 n++;
      end
      check("busy_off", flash_busy_o, 0);
   endtask

   task automatic t_hw_reset();
      int n;
      xfer(1, 0, 24'h000555, 16'h0070);
      @(posedge clk_i);
      hw_reset_i <= 1'b1;
      @(posedge clk_i);
      hw_reset_i <= 1'b0;
      #1 n = 0;
      while (frst_n !== 1'b1 && n < 20) begin
         check("rst_ready", ready_o, 0);
         @(posedge clk_i);
         #1 n++;
      end
      check("rst_len", n, 5);
      wait_ready();
      xfer(0, 0, 24'h000010, 0);
      check("post_rst", rdata_o, 16'hFFFF);
   endtask

   task automatic t_wp(input logic v);
      int n;
      @(posedge clk_i);
      wp_release_i <= v;
      @(posedge clk_i);
      #1 check("wp_pin", wp_n, v);
      xfer(1, 0, 24'hFF8100, 16'h0030);
      repeat (5) @(posedge clk_i);
      #1 check("wp_guard", flash_busy_o, v);
      n = 0;
      while (flash_busy_o !== 1'b0 && n < 30) begin
         @(posedge clk_i);
         #1 n++;
      end
   endtask

   initial begin
      rst_n_i = 1'b0;
      req_i = 1'b0;
      req_we_i = 1'b0;
      req_status_i = 1'b0;
      req_addr_i = '0;
      req_wdata_i = '0;
      hw_reset_i = 1'b0;
      wp_release_i = 1'b0;
      bad_count = 0;
      samples_checked = 0;
      cycles = 0;
      t_reset_state();
      t_reads();
      t_busy();
      t_hw_reset();
      t_wp(1'b1);
      t_wp(1'b0);
      test_done();
   end
endmodule
